// ==== odl_pkg.sv ====
/*
 * odl_pkg: constants and types of the octal dac serial load logic.
 * assumes: included first; shared by the core, the checker, the host and the testbench.
 */
package odl_pkg;
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam int N_DAC = 8;
  localparam int CODE_W = 12;
  localparam int FIFO_DEPTH = 4;
  localparam logic [CNT_W-1:0] BITS_PER_FRAME = 5'h10;
  // command word fields: [15] control flag, [14:12] channel, [11:0] code
  localparam int CTRL_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 12;
  localparam int CODE_HI = 11;
  // control word fields: [1] buffer enable, [0] supply select, [2] reference group
  localparam int GAIN_BUF_BIT = 1;
  localparam int SUPPLY_BIT = 0;
  localparam int GROUP_BIT = 2;
  // link timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SCLK_MIN_PERIOD_PS = 33000;
  localparam int SCLK_MIN_CYCLES = (SCLK_MIN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  typedef enum logic [1:0] {ODL_REF_UNBUF, ODL_REF_BUF, ODL_REF_SUPPLY} odl_ref_t;
endpackage

// ==== odl_fifo_if.sv ====
/*
 * odl_fifo_if: carrier between the serial core and the word fifo.
 * assumes: both ends share one clock.
 */
interface odl_fifo_if #(parameter int W = 16);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport core (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// ==== odl_fifo.sv ====
/*
 * odl_fifo: small word fifo with valid/ready on both sides.
 * assumes: synchronous active low reset, one clock.
 */
module odl_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  odl_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign f.in_ready = (count != (AW+1)'(DEPTH));
  assign f.out_valid = (count != '0);
  assign f.out_data = mem[rd_ptr];
  assign push = f.in_valid && f.in_ready;
  assign pop = f.out_valid && f.out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= f.in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // odl_fifo

// ==== odl_core.sv ====
/*
 * odl_core: serial write logic of an octal dac; frame sync, serial clock and data
 * are sampled by I_CLK, words pass a fifo and land in input and dac registers or in the reference selects.
 * assumes: I_CLK much faster than the serial clock; link pins asynchronous.
 */
module odl_core
  import odl_pkg::*;
#(
  parameter int N = odl_pkg::N_DAC
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_SYNC_N,
  input wire logic I_SCLK,
  input wire logic I_DIN,
  input wire logic I_LOAD_UPDATE_N,
  output logic O_BUF_PWR_ON,
  output logic [odl_pkg::CODE_W*odl_pkg::N_DAC-1:0] O_DAC_CODE,
  output logic [odl_pkg::N_DAC-1:0] O_PENDING,
  output odl_pkg::odl_ref_t O_REF_SEL_ABCD,
  output odl_pkg::odl_ref_t O_REF_SEL_EFGH,
  output logic O_LINK_STALL
);
  import odl_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0] sync_s;
  logic [2:0] sclk_s;
  logic [2:0] din_s;
  logic [2:0] ld_s;
  logic sync_lvl;
  logic sclk_lvl;
  logic ld_lvl;

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      sync_s <= 3'h7;
      sclk_s <= 3'h7;
      din_s <= 3'h0;
      ld_s <= 3'h7;
    end else begin
      sync_s <= {sync_s[1:0], I_SYNC_N};
      sclk_s <= {sclk_s[1:0], I_SCLK};
      din_s <= {din_s[1:0], I_DIN};
      ld_s <= {ld_s[1:0], I_LOAD_UPDATE_N};
    end
  end

  // a level counts once stages two and three agree
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      sync_lvl <= 1'b1;
      sclk_lvl <= 1'b1;
      ld_lvl <= 1'b1;
    end else begin
      if (sync_s[1] == sync_s[2]) begin
        sync_lvl <= sync_s[2];
      end
      if (sclk_s[1] == sclk_s[2]) begin
        sclk_lvl <= sclk_s[2];
      end
      if (ld_s[1] == ld_s[2]) begin
        ld_lvl <= ld_s[2];
      end
    end
  end

  logic sync_fall;
  logic sync_rise;
  logic sclk_fall;
  assign sync_fall = sync_lvl && (sync_s[1] == sync_s[2]) && !sync_s[2];
  assign sync_rise = !sync_lvl && (sync_s[1] == sync_s[2]) && sync_s[2];
  assign sclk_fall = sclk_lvl && (sclk_s[1] == sclk_s[2]) && !sclk_s[2];

  // ************************************************************
  // frame state and shift register
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} odl_state_t;
  odl_state_t state;
  logic buf_pwr;
  logic [WORD_W-1:0] shreg;
  logic [CNT_W-1:0] bit_cnt;
  logic commit;
  odl_fifo_if #(.W(WORD_W)) fif ();

  assign commit = (state == ST_SHIFT) && sclk_fall && (bit_cnt == BITS_PER_FRAME - 1'b1);

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (sync_fall) begin
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (sync_rise) begin
            state <= ST_IDLE;
          end else if (commit) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (sync_rise) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      shreg <= '0;
      bit_cnt <= '0;
    end else if (state != ST_SHIFT || sync_rise) begin
      bit_cnt <= '0;
    end else if (sclk_fall) begin
      shreg <= {shreg[WORD_W-2:0], din_s[2]};
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // buffers on from frame start until the sixteenth edge or an abort
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      buf_pwr <= 1'b0;
    end else if (state == ST_IDLE && sync_fall) begin
      buf_pwr <= 1'b1;
    end else if (state == ST_SHIFT && (sync_rise || commit)) begin
      buf_pwr <= 1'b0;
    end
  end

  assign O_BUF_PWR_ON = buf_pwr;
  assign O_LINK_STALL = !fif.in_ready;

  // ************************************************************
  // word fifo
  // ************************************************************
  assign fif.in_valid = commit;
  assign fif.in_data = {shreg[WORD_W-2:0], din_s[2]};
  assign fif.out_ready = 1'b1;

  odl_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .f(fif.fifo)
  );

  // ************************************************************
  // input, dac and control registers
  // ************************************************************
  logic [CODE_W-1:0] in_reg [N];
  logic [CODE_W-1:0] dac_reg [N];
  logic [N-1:0] pending;
  logic [2:0] wr_ch;
  logic wr_code;
  logic wr_ctrl;
  logic [WORD_W-1:0] word;

  assign word = fif.out_data;
  assign wr_ch = word[ADDR_HI:ADDR_LO];
  assign wr_code = fif.out_valid && !word[CTRL_BIT];
  assign wr_ctrl = fif.out_valid && word[CTRL_BIT];

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      pending <= '0;
      for (int i = 0; i < N; i++) begin
        in_reg[i] <= '0;
        dac_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr_code && wr_ch == 3'(i)) begin
          in_reg[i] <= word[CODE_HI:0];
        end
        if (!ld_lvl && pending[i]) begin
          dac_reg[i] <= in_reg[i];
        end
      end
      // a new write in the update cycle stays pending
      pending <= (pending & ~({N{!ld_lvl}})) |
                 (wr_code ? (N'(1) << wr_ch) : '0);
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_REF_SEL_ABCD <= ODL_REF_UNBUF;
      O_REF_SEL_EFGH <= ODL_REF_UNBUF;
    end else if (wr_ctrl) begin
      if (!word[GROUP_BIT]) begin
        O_REF_SEL_ABCD <= word[SUPPLY_BIT] ? ODL_REF_SUPPLY :
                          word[GAIN_BUF_BIT] ? ODL_REF_BUF : ODL_REF_UNBUF;
      end else begin
        O_REF_SEL_EFGH <= word[SUPPLY_BIT] ? ODL_REF_SUPPLY :
                          word[GAIN_BUF_BIT] ? ODL_REF_BUF : ODL_REF_UNBUF;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      O_DAC_CODE[i*CODE_W +: CODE_W] = dac_reg[i];
    end
  end
  assign O_PENDING = pending;
endmodule // odl_core

// ==== odl_core_checker.sv ====
/* odl_core_checker: port checks of odl_core.
   assumes: bound to odl_core, one clock, sync active low reset. */
module odl_core_checker
  import odl_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_SYNC_N,
  input wire logic I_LOAD_UPDATE_N,
  input wire logic O_BUF_PWR_ON,
  input wire logic [odl_pkg::CODE_W*odl_pkg::N_DAC-1:0] O_DAC_CODE,
  input wire logic [odl_pkg::N_DAC-1:0] O_PENDING,
  input wire odl_pkg::odl_ref_t O_REF_SEL_ABCD,
  input wire odl_pkg::odl_ref_t O_REF_SEL_EFGH,
  input wire logic O_LINK_STALL
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  a_pwr_on_sync: assert property ($fell(I_SYNC_N) |-> ##[1:8] O_BUF_PWR_ON)
    else $error("buffers not powered after frame start");
  a_dac_hold: assert property (I_LOAD_UPDATE_N [*8] |=> $stable(O_DAC_CODE))
    else $error("dac changed without load");
  a_dac_pending: assert property ($changed(O_DAC_CODE) |-> $past(O_PENDING) != 8'h0)
    else $error("dac changed with nothing pending");
  a_load_tied: assert property ((!I_LOAD_UPDATE_N) [*8] |-> ##[0:3] O_PENDING == 8'h0)
    else $error("pending held under tied load");
  a_pend_commit: assert property ($rose(|O_PENDING) |-> !I_SYNC_N && !O_BUF_PWR_ON)
    else $error("commit outside a frame");
  a_ref_commit: assert property (($changed(O_REF_SEL_ABCD) || $changed(O_REF_SEL_EFGH)) |-> !I_SYNC_N)
    else $error("ref select changed outside a frame");
  a_ref_legal: assert property (O_REF_SEL_ABCD != 2'h3 && O_REF_SEL_EFGH != 2'h3)
    else $error("illegal ref select");
  a_ref_one_group: assert property ($changed(O_REF_SEL_ABCD) |-> $stable(O_REF_SEL_EFGH))
    else $error("both reference groups changed by one write");
  a_stall_never: assert property (!O_LINK_STALL)
    else $error("link stalled");
  c_frame: cover property ($rose(O_BUF_PWR_ON));
  c_commit: cover property ($rose(|O_PENDING));
  c_ref: cover property ($changed(O_REF_SEL_EFGH));
endmodule // odl_core_checker

bind odl_core odl_core_checker u_odl_core_checker (.I_CLK, .I_RST_N, .I_SYNC_N,
  .I_LOAD_UPDATE_N, .O_BUF_PWR_ON, .O_DAC_CODE, .O_PENDING, .O_REF_SEL_ABCD,
  .O_REF_SEL_EFGH, .O_LINK_STALL);

// ==== odl_host.sv ====
/* odl_host: serial host writing frames, msb first.
   assumes: i_clk 5 ns; serial clock 125 ns, idle high. */
module odl_host
  import odl_pkg::*;
(
  input wire logic i_clk,
  output logic o_sync_n,
  output logic o_sclk,
  output logic o_din
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sync_n = 1'b1;
    o_sclk = 1'b1;
    o_din = 1'b0;
  end
  // n below 16 ends the frame early
  task automatic send(input logic [WORD_W-1:0] w, input int n);
    @(posedge i_clk) o_sync_n <= 1'b0;
    repeat (12) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_din <= w[WORD_W-1-i];
      repeat (13) @(posedge i_clk);
      o_sclk <= 1'b0;
      repeat (12) @(posedge i_clk);
      o_sclk <= 1'b1;
    end
    repeat (20) @(posedge i_clk);
    o_sync_n <= 1'b1;
    o_din <= ~o_din;
    repeat (20) @(posedge i_clk);
  endtask
endmodule // odl_host

// ==== odl_core_tb.sv ====
/* odl_core_tb: random and corner writes through the serial host.
   assumes: odl_core, odl_host and checker compiled first. */
module odl_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import odl_pkg::*;
  logic clk, rst_n, ld_n, sync_n, sclk, din, pwr, stall;
  logic [CODE_W*N_DAC-1:0] code;
  logic [N_DAC-1:0] pend, exp_pend;
  odl_ref_t ref_a, ref_e;
  logic [CODE_W-1:0] in_reg [N_DAC];
  logic [CODE_W-1:0] dac [N_DAC];
  int failures, num_checks;
  odl_core u_odl_core (.I_CLK(clk), .I_RST_N(rst_n), .I_SYNC_N(sync_n), .I_SCLK(sclk),
    .I_DIN(din), .I_LOAD_UPDATE_N(ld_n), .O_BUF_PWR_ON(pwr), .O_DAC_CODE(code),
    .O_PENDING(pend), .O_REF_SEL_ABCD(ref_a), .O_REF_SEL_EFGH(ref_e), .O_LINK_STALL(stall));
  odl_host u_odl_host (.i_clk(clk), .o_sync_n(sync_n), .o_sclk(sclk), .o_din(din));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [CODE_W*N_DAC-1:0] pack();
    logic [CODE_W*N_DAC-1:0] v;
    for (int i = 0; i < N_DAC; i++) v[i*CODE_W +: CODE_W] = dac[i];
    return v;
  endfunction
  function automatic odl_ref_t exp_ref(logic b, logic s);
    return s ? ODL_REF_SUPPLY : (b ? ODL_REF_BUF : ODL_REF_UNBUF);
  endfunction
  task automatic chk_vec(logic [95:0] got, logic [95:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_ref(odl_ref_t got, odl_ref_t exp);
    chk_vec({94'h0, got}, {94'h0, exp});
  endtask
  task automatic wr(logic [2:0] ch, logic [CODE_W-1:0] v);
    u_odl_host.send({1'b0, ch, v}, 16);
    in_reg[ch] = v;
    if (ld_n) exp_pend[ch] = 1'b1;
    else dac[ch] = v;
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200us;
    failures++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    ld_n = 1'b1;
    exp_pend = 8'h0;
    failures = 0;
    num_checks = 0;
    for (int i = 0; i < N_DAC; i++) dac[i] = 12'h0;
    void'($urandom(93547));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk_vec(code, pack());
    chk_ref(ref_a, ODL_REF_UNBUF);
    $display("test reset done");
    for (int i = 0; i < N_DAC; i++) wr(i[2:0], 12'($urandom));
    wr(3'h5, 12'h801);
    chk_vec(pend, exp_pend);
    chk_vec(pwr, 0);
    chk_vec(code, pack());
    @(posedge clk) ld_n <= 1'b0;
    repeat (4) @(posedge clk);
    ld_n <= 1'b1;
    repeat (10) @(posedge clk);
    for (int i = 0; i < N_DAC; i++) dac[i] = in_reg[i];
    exp_pend = 8'h0;
    chk_vec(code, pack());
    chk_vec(pend, exp_pend);
    $display("test update done");
    fork
      u_odl_host.send({1'b0, 3'h2, 12'habc}, 15);
      begin
        repeat (40) @(posedge clk);
        chk_vec(pwr, 1);
      end
    join
    chk_vec(pwr, 0);
    chk_vec(pend, exp_pend);
    wr(3'h2, 12'h5a5);
    chk_vec(pend, exp_pend);
    $display("test abort done");
    for (int k = 0; k < 8; k++) begin
      u_odl_host.send({1'b1, 12'h0, 3'(k)}, 16);
      chk_ref(k[2] ? ref_e : ref_a, exp_ref(k[1], k[0]));
    end
    chk_vec(code, pack());
    chk_vec(stall, 0);
    $display("test ref done");
    @(posedge clk) ld_n <= 1'b0;
    repeat (10) @(posedge clk);
    dac[2] = in_reg[2];
    wr(3'($urandom), 12'($urandom));
    chk_vec(code, pack());
    $display("test tied done");
    wrap_up();
  end
endmodule // odl_core_tb
